//--- hw/frd_pkg.sv
// Constants and types shared by the serial memory read path
package frd_pkg;

	// ********************************************
	// Array geometry
	// ********************************************
	localparam int           ADDR_W     = 9;
	localparam int           WORD_W     = 8;
	localparam int           MEM_DEPTH  = 512;
	localparam logic [8:0]   ADDR_RST   = 9'h000;
	localparam logic [8:0]   ADDR_FIRST = 9'h000;
	localparam logic [8:0]   ADDR_LAST  = 9'h1FF;
	localparam logic [8:0]   ADDR_STEP  = 9'h001;

	// ********************************************
	// Target address byte layout
	// ********************************************
	localparam int           SA_TYPE_HI = 7;
	localparam int           SA_TYPE_LO = 4;
	localparam int           SA_SEL_HI  = 3;
	localparam int           SA_SEL_LO  = 2;
	localparam int           SA_PAGE    = 1;
	localparam int           SA_DIR     = 0;
	localparam logic         DIR_READ   = 1'b1;

	// ********************************************
	// Bit counting and reset values
	// ********************************************
	localparam logic [2:0]   BIT_FIRST  = 3'h0;
	localparam logic [2:0]   BIT_LAST   = 3'h7;
	localparam logic [2:0]   BIT_STEP   = 3'h1;
	localparam logic [7:0]   BYTE_RST   = 8'h00;

	// ********************************************
	// Link state machine
	// ********************************************
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_SLAVE = 3'b001,
		ST_WORD  = 3'b010,
		ST_WDATA = 3'b011,
		ST_ACK   = 3'b100,
		ST_RDATA = 3'b101,
		ST_RACK  = 3'b110
	} frd_state_type;

endpackage : frd_pkg

//--- hw/frd_sync.sv
// Two-stage synchroniser for signals entering a clock domain
`timescale 1ns/1ps
module frd_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  logic         clk,
	input  logic         rst_n,
	// Data
	input  logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] q_ff;

	// First stage feeds only the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= '0;
			q_ff    <= '0;
		end else begin
			meta_ff <= d;
			q_ff    <= meta_ff;
		end
	end

	assign q = q_ff;

endmodule : frd_sync

//--- hw/frd_mem.sv
// 512 x 8 storage array with registered read data
`timescale 1ns/1ps
module frd_mem
	import frd_pkg::*;
(
	// Clock
	input  logic              clk,
	// Write port
	input  logic              we,
	input  logic [ADDR_W-1:0] waddr,
	input  logic [WORD_W-1:0] wdata,
	// Read port
	input  logic              re,
	input  logic [ADDR_W-1:0] raddr,
	output logic [WORD_W-1:0] rdata
);
	logic [WORD_W-1:0] mem_ff [MEM_DEPTH];
	logic [WORD_W-1:0] rdata_ff;

	always_ff @(posedge clk) begin
		if (we) begin
			mem_ff[waddr] <= wdata;
		end
	end

	// Read data only moves on a read, so it stays stable for the other domain
	always_ff @(posedge clk) begin
		if (re) begin
			rdata_ff <= mem_ff[raddr];
		end
	end

	assign rdata = rdata_ff;

endmodule : frd_mem

//--- hw/frd_top.sv
// Serial memory target: read path, address latch and word fetch across clock domains
//
// Summary of operation
// - Current read takes low address from latch
// - Current read starts after last accessed location
// - Page bit sits above the 8-bit latch
// - Data shifts out on clock after address ack
// - Address counter advances after every sent byte
// - Master ack means send next sequential byte
// - Address 1FFh wraps to 000h on reads
// - Word address loads latch and is acknowledged
// - Repeated START abandons write, read then follows
// - Address byte: type, select pins, page, direction
// - All bytes move most significant bit first
// - Any START aborts and awaits address byte
`timescale 1ns/1ps
module frd_top
	import frd_pkg::*;
#(
	// Arbitrary neutral device type code
	parameter logic [3:0] DEV_TYPE_CODE = 4'h5
) (
	// System clock and reset
	input  logic              REF_CLK,
	input  logic              RSTN,
	// Link clock, oversamples the serial bus
	input  logic              LINK_CLK,
	// Serial bus pins
	input  logic              SCL_IN,
	input  logic              SDA_IN,
	output logic              SDA_OUT,
	output logic              SDA_OE,
	// Select straps
	input  logic [1:0]        DEVICE_SELECT_PINS,
	// Array preload port, system clock
	input  logic              LOAD_WE,
	input  logic [ADDR_W-1:0] LOAD_ADDR,
	input  logic [WORD_W-1:0] LOAD_DATA,
	// Status, system clock
	output logic              BUSY
);

	// ********************************************
	// Link domain: pin synchronisers
	// ********************************************
	logic [3:0]  pins_s;
	logic        scl_s;
	logic        sda_s;
	logic [1:0]  sel_s;

	frd_sync #(.W(4)) u_pin_sync (
		.clk   (LINK_CLK),
		.rst_n (RSTN),
		.d     ({SCL_IN, SDA_IN, DEVICE_SELECT_PINS}),
		.q     (pins_s)
	);

	assign scl_s = pins_s[3];
	assign sda_s = pins_s[2];
	assign sel_s = pins_s[1:0];

	// ********************************************
	// Link domain: bus condition detection
	// ********************************************
	logic scl_q_ff;
	logic sda_q_ff;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;

	always_ff @(posedge LINK_CLK or negedge RSTN) begin
		if (!RSTN) begin
			scl_q_ff <= 1'b0;
			sda_q_ff <= 1'b0;
		end else begin
			scl_q_ff <= scl_s;
			sda_q_ff <= sda_s;
		end
	end

	assign scl_rise  = scl_s & ~scl_q_ff;
	assign scl_fall  = ~scl_s & scl_q_ff;
	assign bus_start = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
	assign bus_stop  = scl_s & scl_q_ff & ~sda_q_ff & sda_s;

	// ********************************************
	// Link domain: fetched byte from the array
	// ********************************************
	logic              done_s;
	logic              done_q_ff;
	logic              done_tgl_ff;
	logic [WORD_W-1:0] mem_rdata;
	logic [WORD_W-1:0] fetched_ff;

	frd_sync #(.W(1)) u_done_sync (
		.clk   (LINK_CLK),
		.rst_n (RSTN),
		.d     (done_tgl_ff),
		.q     (done_s)
	);

	// Array read data is held still once the done toggle lands
	always_ff @(posedge LINK_CLK or negedge RSTN) begin
		if (!RSTN) begin
			done_q_ff  <= 1'b0;
			fetched_ff <= BYTE_RST;
		end else begin
			done_q_ff <= done_s;
			if (done_s != done_q_ff) begin
				fetched_ff <= mem_rdata;
			end
		end
	end

	// ********************************************
	// Link domain: next-state logic
	// ********************************************
	frd_state_type     state_ff;
	frd_state_type     ack_ret_ff;
	logic [2:0]        bit_cnt_ff;
	logic [WORD_W-1:0] shift_ff;
	logic              ack_phase_ff;
	logic              sda_oe_ff;
	logic              sda_out_ff;
	logic [ADDR_W-1:0] addr_ff;
	logic [ADDR_W-1:0] fetch_addr_ff;
	logic              fetch_tgl_ff;
	logic              busy_lk_ff;

	frd_state_type     nxt_state;
	frd_state_type     nxt_ack_ret;
	logic [2:0]        nxt_bit_cnt;
	logic [WORD_W-1:0] nxt_shift;
	logic              nxt_ack_phase;
	logic              nxt_sda_oe;
	logic [ADDR_W-1:0] nxt_addr;
	logic [ADDR_W-1:0] nxt_fetch_addr;
	logic              fetch_req;
	logic [WORD_W-1:0] rx_byte;
	logic              addr_hit;
	logic [ADDR_W-1:0] addr_inc;

	assign rx_byte = {shift_ff[WORD_W-2:0], sda_s};
	assign addr_hit = (rx_byte[SA_TYPE_HI:SA_TYPE_LO] == DEV_TYPE_CODE) &&
		(rx_byte[SA_SEL_HI:SA_SEL_LO] == sel_s);
	assign addr_inc = (addr_ff == ADDR_LAST) ? ADDR_FIRST : addr_ff + ADDR_STEP;

	always_comb begin
		nxt_state      = state_ff;
		nxt_ack_ret    = ack_ret_ff;
		nxt_bit_cnt    = bit_cnt_ff;
		nxt_shift      = shift_ff;
		nxt_ack_phase  = ack_phase_ff;
		nxt_sda_oe     = sda_oe_ff;
		nxt_addr       = addr_ff;
		nxt_fetch_addr = fetch_addr_ff;
		fetch_req      = 1'b0;
		if (bus_start) begin
			nxt_state     = ST_SLAVE;
			nxt_bit_cnt   = BIT_FIRST;
			nxt_ack_phase = 1'b0;
			nxt_sda_oe    = 1'b0;
		end else if (bus_stop) begin
			nxt_state     = ST_IDLE;
			nxt_ack_phase = 1'b0;
			nxt_sda_oe    = 1'b0;
		end else begin
			case (state_ff)
				ST_IDLE: begin
					nxt_sda_oe = 1'b0;
				end
				ST_SLAVE: begin
					if (scl_rise) begin
						nxt_shift   = rx_byte;
						nxt_bit_cnt = bit_cnt_ff + BIT_STEP;
						if (bit_cnt_ff == BIT_LAST) begin
							if (addr_hit) begin
								nxt_addr  = {rx_byte[SA_PAGE], addr_ff[WORD_W-1:0]};
								nxt_state = ST_ACK;
								if (rx_byte[SA_DIR] == DIR_READ) begin
									nxt_ack_ret = ST_RDATA;
									nxt_fetch_addr = {rx_byte[SA_PAGE], addr_ff[WORD_W-1:0]};
									fetch_req      = 1'b1;
								end else begin
									nxt_ack_ret = ST_WORD;
								end
							end else begin
								nxt_state = ST_IDLE;
							end
						end
					end
				end
				ST_WORD: begin
					if (scl_rise) begin
						nxt_shift   = rx_byte;
						nxt_bit_cnt = bit_cnt_ff + BIT_STEP;
						if (bit_cnt_ff == BIT_LAST) begin
							nxt_addr    = {addr_ff[ADDR_W-1], rx_byte};
							nxt_state   = ST_ACK;
							nxt_ack_ret = ST_WDATA;
						end
					end
				end
				ST_WDATA: begin
					if (scl_rise) begin
						nxt_shift   = rx_byte;
						nxt_bit_cnt = bit_cnt_ff + BIT_STEP;
						if (bit_cnt_ff == BIT_LAST) begin
							nxt_addr    = addr_inc;
							nxt_state   = ST_ACK;
							nxt_ack_ret = ST_WDATA;
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						if (!ack_phase_ff) begin
							// pull low for the ninth clock
							nxt_sda_oe    = 1'b1;
							nxt_ack_phase = 1'b1;
						end else begin
							nxt_ack_phase = 1'b0;
							nxt_sda_oe    = 1'b0;
							nxt_bit_cnt   = BIT_FIRST;
							nxt_state     = ack_ret_ff;
							if (ack_ret_ff == ST_RDATA) begin
								nxt_shift      = fetched_ff;
								nxt_sda_oe     = ~fetched_ff[WORD_W-1];
								nxt_addr       = addr_inc;
								nxt_fetch_addr = addr_inc;
								fetch_req      = 1'b1;
							end
						end
					end
				end
				ST_RDATA: begin
					if (scl_fall) begin
						if (bit_cnt_ff == BIT_LAST) begin
							nxt_sda_oe = 1'b0;
							nxt_state  = ST_RACK;
						end else begin
							nxt_bit_cnt = bit_cnt_ff + BIT_STEP;
							nxt_sda_oe  = ~shift_ff[WORD_W-2];
							nxt_shift   = {shift_ff[WORD_W-2:0], 1'b0};
						end
					end
				end
				ST_RACK: begin
					if (scl_rise && sda_s) begin
						nxt_state = ST_IDLE;
					end else if (scl_fall) begin
						nxt_state      = ST_RDATA;
						nxt_bit_cnt    = BIT_FIRST;
						nxt_shift      = fetched_ff;
						nxt_sda_oe     = ~fetched_ff[WORD_W-1];
						nxt_addr       = addr_inc;
						nxt_fetch_addr = addr_inc;
						fetch_req      = 1'b1;
					end
				end
				default: begin
					nxt_state  = ST_IDLE;
					nxt_sda_oe = 1'b0;
				end
			endcase
		end
	end

	// ********************************************
	// Link domain: protocol state
	// ********************************************
	always_ff @(posedge LINK_CLK or negedge RSTN) begin
		if (!RSTN) begin
			state_ff     <= ST_IDLE;
			ack_ret_ff   <= ST_IDLE;
			bit_cnt_ff   <= BIT_FIRST;
			shift_ff     <= BYTE_RST;
			ack_phase_ff <= 1'b0;
			busy_lk_ff   <= 1'b0;
		end else begin
			state_ff     <= nxt_state;
			ack_ret_ff   <= nxt_ack_ret;
			bit_cnt_ff   <= nxt_bit_cnt;
			shift_ff     <= nxt_shift;
			ack_phase_ff <= nxt_ack_phase;
			busy_lk_ff   <= (nxt_state != ST_IDLE);
		end
	end

	// ********************************************
	// Link domain: SDA drive, open drain
	// ********************************************
	always_ff @(posedge LINK_CLK or negedge RSTN) begin
		if (!RSTN) begin
			sda_oe_ff  <= 1'b0;
			sda_out_ff <= 1'b0;
		end else begin
			sda_oe_ff  <= nxt_sda_oe;
			sda_out_ff <= 1'b0;
		end
	end

	assign SDA_OE  = sda_oe_ff;
	assign SDA_OUT = sda_out_ff;

	// ********************************************
	// Link domain: address latch and fetch request
	// ********************************************
	// Address is held still between toggles so it may cross as a bus
	always_ff @(posedge LINK_CLK or negedge RSTN) begin
		if (!RSTN) begin
			addr_ff       <= ADDR_RST;
			fetch_addr_ff <= ADDR_RST;
			fetch_tgl_ff  <= 1'b0;
		end else begin
			addr_ff <= nxt_addr;
			if (fetch_req) begin
				fetch_addr_ff <= nxt_fetch_addr;
				fetch_tgl_ff  <= ~fetch_tgl_ff;
			end
		end
	end

	// ********************************************
	// System domain: array read service
	// ********************************************
	logic fetch_s;
	logic fetch_q_ff;
	logic rd_en;
	logic rd_pend_ff;

	frd_sync #(.W(1)) u_fetch_sync (
		.clk   (REF_CLK),
		.rst_n (RSTN),
		.d     (fetch_tgl_ff),
		.q     (fetch_s)
	);

	assign rd_en = fetch_s ^ fetch_q_ff;

	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			fetch_q_ff  <= 1'b0;
			rd_pend_ff  <= 1'b0;
			done_tgl_ff <= 1'b0;
		end else begin
			fetch_q_ff <= fetch_s;
			rd_pend_ff <= rd_en;
			if (rd_pend_ff) begin
				done_tgl_ff <= ~done_tgl_ff;
			end
		end
	end

	frd_mem u_mem (
		.clk   (REF_CLK),
		.we    (LOAD_WE),
		.waddr (LOAD_ADDR),
		.wdata (LOAD_DATA),
		.re    (rd_en),
		.raddr (fetch_addr_ff),
		.rdata (mem_rdata)
	);

	// ********************************************
	// System domain: busy status
	// ********************************************
	logic busy_s;

	frd_sync #(.W(1)) u_busy_sync (
		.clk   (REF_CLK),
		.rst_n (RSTN),
		.d     (busy_lk_ff),
		.q     (busy_s)
	);

	assign BUSY = busy_s;

endmodule : frd_top

//--- dv/frd_top_monitor.sv
// Pin-level checks for the serial memory target
`timescale 1ns/1ps
module frd_top_monitor
	import frd_pkg::*;
#(
	parameter logic [3:0] DEV_TYPE_CODE = 4'h5
) (
	// Clock and reset
	input logic       LINK_CLK,
	input logic       RSTN,
	// Bus and status
	input logic       SCL_IN,
	input logic       SDA_IN,
	input logic       SDA_OE,
	input logic [1:0] DEVICE_SELECT_PINS,
	input logic       BUSY
);
	logic       scl_ff, sda_ff, first_ff, rd_ff, quiet_ff;
	logic [3:0] pos_ff;
	logic [7:0] sh_ff;
	logic [6:0] idle_ff;
	logic       rise, strt, stp, match;
	assign rise  = SCL_IN & ~scl_ff;
	assign strt  = SCL_IN & scl_ff & sda_ff & ~SDA_IN;
	assign stp   = SCL_IN & scl_ff & ~sda_ff & SDA_IN;
	assign match = (sh_ff[7:4] == DEV_TYPE_CODE) && (sh_ff[3:2] == DEVICE_SELECT_PINS);
	default clocking cb @(posedge LINK_CLK); endclocking
	default disable iff (!RSTN);
	always_ff @(posedge LINK_CLK or negedge RSTN) begin
		if (!RSTN) begin
			scl_ff  <= 1'b1;
			sda_ff  <= 1'b1;
			idle_ff <= 7'h00;
		end else begin
			scl_ff  <= SCL_IN;
			sda_ff  <= SDA_IN;
			idle_ff <= (SCL_IN && SDA_IN) ? idle_ff + {6'h00, idle_ff < 7'h7F} : 7'h00;
		end
	end
	// Raw pins, so this tracker runs ahead of the design
	always_ff @(posedge LINK_CLK or negedge RSTN) begin
		if (!RSTN) begin
			pos_ff   <= 4'h0;
			sh_ff    <= 8'h00;
			first_ff <= 1'b0;
			rd_ff    <= 1'b0;
			quiet_ff <= 1'b1;
		end else if (strt) begin
			pos_ff   <= 4'h0;
			first_ff <= 1'b1;
			rd_ff    <= 1'b0;
			quiet_ff <= 1'b0;
		end else if (stp) begin
			quiet_ff <= 1'b1;
		end else if (rise) begin
			pos_ff <= (pos_ff == 4'h8) ? 4'h0 : pos_ff + 4'h1;
			if (pos_ff < 4'h8)
				sh_ff <= {sh_ff[6:0], SDA_IN};
			if (pos_ff == 4'h8 && first_ff) begin
				first_ff <= 1'b0;
				rd_ff    <= match & sh_ff[0];
				quiet_ff <= ~match;
			end else if (pos_ff == 4'h8 && rd_ff && SDA_IN)
				quiet_ff <= 1'b1;
		end
	end
	property p_addr_ack;
		rise && first_ff && pos_ff == 4'h8 |-> SDA_OE == match;
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("address ack wrong");
	property p_word_ack;
		rise && !first_ff && !rd_ff && !quiet_ff && pos_ff == 4'h8 |-> SDA_OE;
	endproperty
	a_word_ack: assert property (p_word_ack) else $error("word address not acked");
	property p_rack_free;
		rise && rd_ff && !first_ff && pos_ff == 4'h8 |-> !SDA_OE;
	endproperty
	a_rack_free: assert property (p_rack_free) else $error("SDA held in master ack bit");
	property p_quiet;
		quiet_ff |-> !SDA_OE;
	endproperty
	a_quiet: assert property (p_quiet) else $error("SDA driven after end of read");
	property p_start_abort;
		first_ff && pos_ff < 4'h8 |-> !SDA_OE;
	endproperty
	a_start_abort: assert property (p_start_abort) else $error("SDA driven during address");
	property p_oe_scl;
		$changed(SDA_OE) |-> !SCL_IN && !$past(SCL_IN) && !$past(SCL_IN, 2);
	endproperty
	a_oe_scl: assert property (p_oe_scl) else $error("SDA moved outside SCL low");
	property p_busy_oe;
		SDA_OE |-> BUSY;
	endproperty
	a_busy_oe: assert property (p_busy_oe) else $error("driving while not busy");
	property p_idle;
		idle_ff > 7'h28 |-> !BUSY ##1 !BUSY;
	endproperty
	a_idle: assert property (p_idle) else $error("busy on idle bus");
endmodule : frd_top_monitor

bind frd_top frd_top_monitor #(.DEV_TYPE_CODE(DEV_TYPE_CODE)) u_mon (
	.LINK_CLK(LINK_CLK), .RSTN(RSTN), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN),
	.SDA_OE(SDA_OE), .DEVICE_SELECT_PINS(DEVICE_SELECT_PINS), .BUSY(BUSY));

//--- dv/frd_master.sv
// Behavioural bus controller facing the serial memory target
`timescale 1ns/1ps
module frd_master (
	// Bus pins
	output logic      scl,
	output logic      sda_rel,
	input  wire logic sda
);
	// Quarter bit: each SCL phase is 8 link clocks
	localparam int Q = 500;
	initial begin
		scl     = 1'b1;
		sda_rel = 1'b1;
	end
	task automatic start();
		#Q sda_rel = 1'b1;
		#Q scl = 1'b1;
		#Q sda_rel = 1'b0;
		#Q scl = 1'b0;
	endtask : start
	task automatic stop();
		#Q sda_rel = 1'b0;
		#Q scl = 1'b1;
		#Q sda_rel = 1'b1;
		#Q;
	endtask : stop
	task automatic bit_io(input logic b, output logic s);
		#Q sda_rel = b;
		#Q scl = 1'b1;
		#Q s = sda;
		#Q scl = 1'b0;
	endtask : bit_io
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(b[i], s);
		bit_io(1'b1, s);
		ack = ~s;
	endtask : wbyte
	// valid ends: ack, nack, STOP or START
	task automatic rbyte(input int m, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		if (m == 2)
			stop();
		else if (m == 3)
			start();
		else
			bit_io(m == 1, s);
	endtask : rbyte
endmodule : frd_master

//--- dv/test_frd_top.sv
// Self-checking bench for the serial memory read path
`timescale 1ns/1ps
module test_frd_top;
	import frd_pkg::*;
	// Arbitrary neutral type code
	localparam logic [3:0] TC = 4'h5;
	logic              REF_CLK = 1'b0;
	logic              LINK_CLK = 1'b0;
	logic              RSTN = 1'b0;
	logic [1:0]        DEVICE_SELECT_PINS = 2'h2;
	logic              LOAD_WE = 1'b0;
	logic [ADDR_W-1:0] LOAD_ADDR = 9'h000;
	logic [WORD_W-1:0] LOAD_DATA = 8'h00;
	logic              SDA_OUT, SDA_OE, BUSY, scl, sda_rel, ack;
	logic [7:0]        d;
	// Pull-up: a released line reads high
	wire               sda = sda_rel & ~SDA_OE;
	int                num_errors = 0;
	int                total_checks = 0;
	always #5 REF_CLK = ~REF_CLK;
	always #62.5 LINK_CLK = ~LINK_CLK;
	frd_top #(.DEV_TYPE_CODE(TC)) uut (.REF_CLK(REF_CLK), .RSTN(RSTN), .LINK_CLK(LINK_CLK),
		.SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
		.DEVICE_SELECT_PINS(DEVICE_SELECT_PINS), .LOAD_WE(LOAD_WE), .LOAD_ADDR(LOAD_ADDR),
		.LOAD_DATA(LOAD_DATA), .BUSY(BUSY));
	frd_master m (.scl(scl), .sda_rel(sda_rel), .sda(sda));
	function automatic logic [7:0] pat(input logic [8:0] a);
		return a[7:0] ^ {a[8], 7'h25};
	endfunction : pat
	function automatic logic [7:0] sa(input logic pg, input logic rd);
		return {TC, DEVICE_SELECT_PINS, pg, rd};
	endfunction : sa
	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch at %0t: byte %h, expected %h", $time, g, e);
		end
	endtask : chk8
	task automatic chk1(input logic g, input logic e);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch at %0t: flag %b, expected %b", $time, g, e);
		end
	endtask : chk1
	task automatic gap();
		repeat (800) @(posedge REF_CLK);
		#1;
		chk1(BUSY, 1'b0);
		chk1(SDA_OUT, 1'b0);
	endtask : gap
	task automatic t_sel();
		m.start();
		m.wbyte(sa(1'b1, 1'b0), ack);
		chk1(ack, 1'b1);
		m.wbyte(8'hFE, ack);
		chk1(ack, 1'b1);
		m.start();
		m.wbyte(sa(1'b1, 1'b1), ack);
		chk1(ack, 1'b1);
		m.rbyte(0, d);
		chk8(d, pat(9'h1FE));
		m.rbyte(0, d);
		chk8(d, pat(9'h1FF));
		m.rbyte(1, d);
		chk8(d, pat(9'h000));
		m.stop();
		gap();
		$display("test selective read done");
	endtask : t_sel
	task automatic t_cur();
		m.start();
		m.wbyte(sa(1'b0, 1'b1), ack);
		chk1(ack, 1'b1);
		m.rbyte(3, d);
		chk8(d, pat(9'h001));
		m.wbyte(sa(1'b1, 1'b1), ack);
		chk1(ack, 1'b1);
		m.rbyte(1, d);
		chk8(d, pat(9'h102));
		m.start();
		m.wbyte(sa(1'b0, 1'b1), ack);
		chk1(ack, 1'b1);
		m.rbyte(2, d);
		chk8(d, pat(9'h003));
		gap();
		$display("test current read done");
	endtask : t_cur
	task automatic t_ref();
		DEVICE_SELECT_PINS = 2'h1;
		repeat (20) @(posedge REF_CLK);
		#1;
		m.start();
		m.wbyte({TC, ~DEVICE_SELECT_PINS, 2'h1}, ack);
		chk1(ack, 1'b0);
		m.start();
		m.wbyte({~TC, DEVICE_SELECT_PINS, 2'h1}, ack);
		chk1(ack, 1'b0);
		m.start();
		repeat (3) m.bit_io(1'b1, ack);
		m.start();
		m.wbyte(sa(1'b0, 1'b1), ack);
		chk1(ack, 1'b1);
		m.rbyte(1, d);
		chk8(d, pat(9'h004));
		m.stop();
		gap();
		$display("test refusal and abort done");
	endtask : t_ref
	task automatic close_out();
		$display("checks %0d, mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : close_out
	initial begin
		repeat (10) @(posedge REF_CLK);
		#1 RSTN = 1'b1;
		for (int i = 0; i < MEM_DEPTH; i++) begin
			@(posedge REF_CLK);
			#1 LOAD_WE = 1'b1;
			LOAD_ADDR = i[8:0];
			LOAD_DATA = pat(i[8:0]);
		end
		@(posedge REF_CLK);
		#1 LOAD_WE = 1'b0;
		gap();
		t_sel();
		t_cur();
		t_ref();
		close_out();
	end
	// Run needs about 0.4 ms
	initial begin
		#1000000;
		num_errors++;
		close_out();
	end
endmodule : test_frd_top
